// [design/bcpm_pkg.sv]
// package: offsets, field positions, reset values for bridge control / pm capability
package bcpm_pkg;
	// ****************************************
	// register offsets (byte addresses, dword aligned)
	// ****************************************
	localparam logic [7:0] OFS_CAP_PTR = 8'h34;
	localparam logic [7:0] OFS_INT_BRIDGE = 8'h3C;
	localparam logic [7:0] OFS_PM_CAP = 8'h40;
	// ****************************************
	// field positions in dword 3Ch
	// ****************************************
	localparam int INT_LINE_LSB = 0;
	localparam int INT_PIN_LSB = 8;
	localparam int BC_POISON_BIT = 16;
	localparam int BC_ERRFWD_BIT = 17;
	localparam int BC_ALIAS_BIT = 18;
	localparam int BC_DISP_BIT = 19;
	localparam int BC_DISP16_BIT = 20;
	localparam int BC_HOTRST_BIT = 22;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] CAP_PTR_RESET = 8'h40;
	localparam logic [7:0] INT_PIN_RESET = 8'h00;
	localparam logic [7:0] PM_CAP_ID = 8'h01;
	localparam logic [7:0] PM_NEXT_UP = 8'h5C;
	localparam logic [7:0] PM_NEXT_DOWN = 8'h4C;
	localparam logic [2:0] PM_REVISION = 3'h3;
	localparam logic DSI_RESET = 1'b0;
	localparam logic [2:0] AUX_CUR_RESET = 3'h7;
	localparam logic D1_RESET = 1'b1;
	localparam logic D2_RESET = 1'b1;
	localparam logic [4:0] WAKE_SUP_RESET = 5'h1F;
	// preload word layout: {wake[4:0], d2, d1, aux[2:0], dsi, intpin[7:0]}
	localparam int PRELOAD_W = 19;
	// ****************************************
	// legacy decode constants
	// ****************************************
	localparam logic [31:0] DISP_MEM_LO = 32'h000A_0000;
	localparam logic [31:0] DISP_MEM_HI = 32'h000B_FFFF;
	localparam logic [9:0] DISP_IO_A_LO = 10'h3B0;
	localparam logic [9:0] DISP_IO_A_HI = 10'h3BB;
	localparam logic [9:0] DISP_IO_B_LO = 10'h3C0;
	localparam logic [9:0] DISP_IO_B_HI = 10'h3DF;
	localparam logic [31:0] IO_64K_LIMIT = 32'h0001_0000;
	localparam logic [1:0] ALIAS_HIGH_QUARTER = 2'h0;
endpackage : bcpm_pkg

// [design/bcpm_bridge_ctrl.sv]
// bridge control word and power management capability header of one switch port
//
// Contract
// - interrupt pin field read-only, resets to zero; hot-plug via INTA message.
// - poisoned-packet response bit clear ignores, set detects/reports secondary poisoned TLPs.
// - error forwarding bit set passes correctable/nonfatal/fatal messages upstream; clear blocks.
// - alias bit set sends upper 768 bytes of each 1KB below 64KB upstream.
// - display enable forwards memory 000A0000h..000BFFFFh; clear ignores it.
// - display I/O only in first 64KB, low bits 3B0-3BBh and 3C0-3DFh.
// - decode width bit: clear compares 10 bits, set compares 16 bits.
// - hot reset bit on downstream port asserts that port's reset output.
// - hot reset bit on upstream port asserts reset at every downstream port.
// - abort, back-to-back, timeouts, discard timer bits read zero; upper four reserved.
// - capability header low byte reads 01h.
// - next pointer resets 5Ch upstream, 4Ch downstream; read-only.
// - revision field reads 011b.
// - device-specific init bit reads zero by default.
// - auxiliary current field resets to 111b (375 mA).
// - D1 and D2 support bits read one.
// - wake-event support field reads 11111b.
// - read-only capability defaults and downstream interrupt pin replaceable by preload.
// - capability list pointer resets to 40h.
`timescale 1ns/100ps
module bcpm_bridge_ctrl #(
	parameter bit IS_UPSTREAM = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration access
	input wire logic cfgRead,
	input wire logic cfgWrite,
	input wire logic [7:0] cfgAddr,
	input wire logic [3:0] cfgByteEn,
	input wire logic [31:0] cfgWrData,
	output logic [31:0] cfgRdData,
	output logic cfgRdValid,
	// default preload from smbus or eeprom
	input wire logic preloadStrobe,
	input wire logic [bcpm_pkg::PRELOAD_W-1:0] preloadData,
	// secondary side events
	input wire logic poisonSeen,
	input wire logic errMsgSeen,
	output logic poisonReport,
	output logic errMsgForward,
	// transaction decode request
	input wire logic decodeValid,
	input wire logic decodeIsIo,
	input wire logic [31:0] decodeAddr,
	input wire logic decodeInIoWindow,
	output logic decodeDownstream,
	output logic decodeUpstream,
	output logic decodeDone,
	// hot reset
	input wire logic upstreamHotReset,
	output logic portResetOut_n
);
	import bcpm_pkg::*;

	// ****************************************
	// state
	// ****************************************
	logic [7:0] intLine_reg;
	logic poisonEn_reg;
	logic errFwdEn_reg;
	logic aliasEn_reg;
	logic dispEn_reg;
	logic disp16_reg;
	logic hotRst_reg;
	logic [7:0] intPin_reg;
	logic dsi_reg;
	logic [2:0] auxCur_reg;
	logic d1Sup_reg;
	logic d2Sup_reg;
	logic [4:0] wakeSup_reg;
	logic [31:0] rdWord;
	logic writeBridge;
	logic dispHit;
	logic aliasHit;

	function automatic logic inRange10(input logic [9:0] a, input logic [9:0] lo,
		input logic [9:0] hi);
		inRange10 = (a >= lo) && (a <= hi);
	endfunction : inRange10

	// ****************************************
	// writable bridge control bits
	// ****************************************
	assign writeBridge = cfgWrite && (cfgAddr == OFS_INT_BRIDGE);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			intLine_reg <= 8'h00;
		end else if (writeBridge && cfgByteEn[0]) begin
			intLine_reg <= cfgWrData[INT_LINE_LSB +: 8];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			poisonEn_reg <= 1'b0;
			errFwdEn_reg <= 1'b0;
			aliasEn_reg <= 1'b0;
			dispEn_reg <= 1'b0;
			disp16_reg <= 1'b0;
			hotRst_reg <= 1'b0;
		end else if (writeBridge && cfgByteEn[2]) begin
			// of the bridge control bytes only byte 2 holds writable bits; byte 3 is all read-only/reserved
			poisonEn_reg <= cfgWrData[BC_POISON_BIT];
			errFwdEn_reg <= cfgWrData[BC_ERRFWD_BIT];
			aliasEn_reg <= cfgWrData[BC_ALIAS_BIT];
			dispEn_reg <= cfgWrData[BC_DISP_BIT];
			disp16_reg <= cfgWrData[BC_DISP16_BIT];
			hotRst_reg <= cfgWrData[BC_HOTRST_BIT];
		end
	end

	// ****************************************
	// preloadable read-only defaults
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			intPin_reg <= INT_PIN_RESET;
			dsi_reg <= DSI_RESET;
			auxCur_reg <= AUX_CUR_RESET;
			d1Sup_reg <= D1_RESET;
			d2Sup_reg <= D2_RESET;
			wakeSup_reg <= WAKE_SUP_RESET;
		end else if (preloadStrobe) begin
			// interrupt pin default is fixed on the upstream port
			if (!IS_UPSTREAM) begin
				intPin_reg <= preloadData[7:0];
			end
			dsi_reg <= preloadData[8];
			auxCur_reg <= preloadData[11:9];
			d1Sup_reg <= preloadData[12];
			d2Sup_reg <= preloadData[13];
			wakeSup_reg <= preloadData[18:14];
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rdWord = 32'h0000_0000;
		unique case (cfgAddr)
			OFS_CAP_PTR: rdWord[7:0] = CAP_PTR_RESET;
			OFS_INT_BRIDGE: begin
				rdWord[INT_LINE_LSB +: 8] = intLine_reg;
				rdWord[INT_PIN_LSB +: 8] = intPin_reg;
				rdWord[BC_POISON_BIT] = poisonEn_reg;
				rdWord[BC_ERRFWD_BIT] = errFwdEn_reg;
				rdWord[BC_ALIAS_BIT] = aliasEn_reg;
				rdWord[BC_DISP_BIT] = dispEn_reg;
				rdWord[BC_DISP16_BIT] = disp16_reg;
				rdWord[BC_HOTRST_BIT] = hotRst_reg;
				// bits 21, 23..31 stay zero
			end
			OFS_PM_CAP: begin
				rdWord[7:0] = PM_CAP_ID;
				rdWord[15:8] = IS_UPSTREAM ? PM_NEXT_UP : PM_NEXT_DOWN;
				rdWord[18:16] = PM_REVISION;
				rdWord[21] = dsi_reg;
				rdWord[24:22] = auxCur_reg;
				rdWord[25] = d1Sup_reg;
				rdWord[26] = d2Sup_reg;
				rdWord[31:27] = wakeSup_reg;
			end
			default: rdWord = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfgRdData <= 32'h0000_0000;
			cfgRdValid <= 1'b0;
		end else begin
			cfgRdValid <= cfgRead;
			if (cfgRead) begin
				cfgRdData <= rdWord;
			end
		end
	end

	// ****************************************
	// secondary event gating
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			poisonReport <= 1'b0;
			errMsgForward <= 1'b0;
		end else begin
			poisonReport <= poisonSeen && poisonEn_reg;
			errMsgForward <= errMsgSeen && errFwdEn_reg;
		end
	end

	// ****************************************
	// legacy address decode
	// ****************************************
	always_comb begin
		dispHit = 1'b0;
		aliasHit = 1'b0;
		if (!decodeIsIo) begin
			dispHit = (decodeAddr >= DISP_MEM_LO) && (decodeAddr <= DISP_MEM_HI);
		end else begin
			// 10-bit decode aliases every 1KB; 16-bit needs bits 15:10 zero
			dispHit = (decodeAddr < IO_64K_LIMIT)
				&& (disp16_reg ? (decodeAddr[15:10] == 6'h00) : 1'b1)
				&& (inRange10(decodeAddr[9:0], DISP_IO_A_LO, DISP_IO_A_HI)
				|| inRange10(decodeAddr[9:0], DISP_IO_B_LO, DISP_IO_B_HI));
			aliasHit = decodeInIoWindow && (decodeAddr < IO_64K_LIMIT)
				&& (decodeAddr[9:8] != ALIAS_HIGH_QUARTER);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			decodeDownstream <= 1'b0;
			decodeUpstream <= 1'b0;
			decodeDone <= 1'b0;
		end else begin
			decodeDone <= decodeValid;
			if (decodeValid) begin
				if (dispEn_reg && dispHit) begin
					decodeDownstream <= 1'b1;
					decodeUpstream <= 1'b0;
				end else if (decodeIsIo && decodeInIoWindow) begin
					// alias mode returns upper 768 bytes of each 1KB upstream
					decodeDownstream <= !(aliasEn_reg && aliasHit);
					decodeUpstream <= aliasEn_reg && aliasHit;
				end else begin
					decodeDownstream <= 1'b0;
					decodeUpstream <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// hot reset output
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			portResetOut_n <= 1'b1;
		end else if (IS_UPSTREAM) begin
			// upstream instance only feeds its bit out; downstream ports act on it
			portResetOut_n <= !hotRst_reg;
		end else begin
			portResetOut_n <= !(hotRst_reg || upstreamHotReset);
		end
	end
endmodule : bcpm_bridge_ctrl

// [test/bcpm_up_model.sv]
// upstream port model driving hot reset fan-out
`timescale 1ns/100ps
module bcpm_up_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// upstream hot reset bit
	input wire logic hotBitSet,
	// fan-out
	output logic upstreamHotReset
);
	// ****
	// fan-out register
	// ****
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			upstreamHotReset <= 1'b0;
		end else begin
			upstreamHotReset <= hotBitSet;
		end
	end
endmodule : bcpm_up_model

// [test/bcpm_chk_assertions.sv]
// port assertions for the bridge control block
`timescale 1ns/100ps
module bcpm_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// config
	input wire logic cfgRead,
	input wire logic [7:0] cfgAddr,
	input wire logic [31:0] cfgRdData,
	input wire logic cfgRdValid,
	// events
	input wire logic poisonSeen,
	input wire logic errMsgSeen,
	input wire logic poisonReport,
	input wire logic errMsgForward,
	// decode and reset
	input wire logic decodeValid,
	input wire logic decodeDone,
	input wire logic decodeDownstream,
	input wire logic decodeUpstream,
	input wire logic upstreamHotReset,
	input wire logic portResetOut_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_answer_a: assert property (cfgRead |=> cfgRdValid) else $error("no read answer");
	rd_spurious_a: assert property (!cfgRead |=> !cfgRdValid) else $error("stray answer");
	cap_ptr_a: assert property (cfgRead && cfgAddr == 8'h34 |=> cfgRdData == 32'h40)
		else $error("cap pointer");
	pm_fixed_a: assert property (cfgRead && cfgAddr == 8'h40
		|=> cfgRdData[18:16] == 3'h3 && cfgRdData[15:0] == 16'h4C01) else $error("pm header");
	bc_zero_a: assert property (cfgRead && cfgAddr == 8'h3C
		|=> cfgRdData[31:23] == 9'h0 && !cfgRdData[21]) else $error("bridge ro bits");
	poison_idle_a: assert property (!poisonSeen |=> !poisonReport) else $error("poison");
	err_idle_a: assert property (!errMsgSeen |=> !errMsgForward) else $error("err fwd");
	dec_done_a: assert property (decodeValid |=> decodeDone) else $error("decode done");
	dec_hold_a: assert property (!decodeValid |=> !decodeDone && $stable(decodeDownstream)
		&& $stable(decodeUpstream)) else $error("decode hold");
	dec_excl_a: assert property (decodeDone |-> !(decodeDownstream && decodeUpstream))
		else $error("decode both ways");
	hot_fanout_a: assert property (upstreamHotReset |=> !portResetOut_n)
		else $error("hot fan-out");
endmodule : bcpm_chk
bind bcpm_bridge_ctrl bcpm_chk i_bcpm_chk (.*);

// [test/tb_bridge_control_pm_capability.sv]
// testbench for the bridge control and pm capability block
`timescale 1ns/100ps
module tb_bridge_control_pm_capability;
	import bcpm_pkg::*;
	logic clk = 0, rst_n = 0, cfgRead = 0, cfgWrite = 0, preloadStrobe = 0, hotBitSet = 0;
	logic poisonSeen = 0, errMsgSeen = 0, decodeValid = 0, decodeIsIo = 0, decodeInIoWindow = 0;
	logic cfgRdValid, poisonReport, errMsgForward, decodeDownstream, decodeUpstream;
	logic decodeDone, portResetOut_n, upstreamHotReset;
	logic [7:0] cfgAddr = 0;
	logic [3:0] cfgByteEn = 0;
	logic [31:0] cfgWrData = 0, decodeAddr = 0, cfgRdData, r, p;
	logic [PRELOAD_W-1:0] preloadData = 0;
	logic [31:0] rdQ[$];
	logic [1:0] decQ[$];
	int fail_count = 0, n_tests = 0, cycles = 0;
	always #10 clk = ~clk;
	bcpm_bridge_ctrl i_bcpm_bridge_ctrl (.*);
	bcpm_up_model i_bcpm_up_model (.*);
	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [31:0] seen, exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		cfgWrite <= 1'b1;
		cfgAddr <= a;
		cfgByteEn <= be;
		cfgWrData <= d;
		@(posedge clk);
		cfgWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		cfgRead <= 1'b1;
		cfgAddr <= a;
		rdQ.push_back(e);
		@(posedge clk);
		cfgRead <= 1'b0;
	endtask : rd
	task automatic dec(input logic io, input logic [31:0] a, input logic w, input logic [1:0] e);
		@(posedge clk);
		decodeValid <= 1'b1;
		decodeIsIo <= io;
		decodeAddr <= a;
		decodeInIoWindow <= w;
		decQ.push_back(e);
		@(posedge clk);
		decodeValid <= 1'b0;
	endtask : dec
	// ****
	// result watcher and timeout
	// ****
	always @(posedge clk) begin
		cycles++;
		if (cfgRdValid === 1'b1) chk(cfgRdData, rdQ.pop_front(), "read");
		if (decodeDone === 1'b1) chk({decodeDownstream, decodeUpstream}, decQ.pop_front(), "dec");
		if (cycles == 2000) begin
			fail_count++;
			end_of_test();
		end
	end
	// ****
	// scenarios
	// ****
	initial begin
		void'($urandom(32'h5AFF9890));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_CAP_PTR, 32'h40);
		rd(OFS_PM_CAP, 32'hFFC3_4C01);
		rd(OFS_INT_BRIDGE, 32'h0);
		r = $urandom();
		wr(OFS_INT_BRIDGE, 4'hF, {24'hFFFFFF, r[7:0]});
		rd(OFS_INT_BRIDGE, {16'h005F, 8'h00, r[7:0]});
		chk(portResetOut_n, 1'b0, "hot reset");
		wr(OFS_PM_CAP, 4'hF, 32'h0);
		rd(OFS_PM_CAP, 32'hFFC3_4C01);
		rd(8'h80, 32'h0);
		wr(OFS_INT_BRIDGE, 4'h4, 32'h0);
		@(posedge clk);
		@(negedge clk);
		chk(portResetOut_n, 1'b1, "hot reset off");
		@(posedge clk);
		hotBitSet <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(portResetOut_n, 1'b0, "fan-out");
		@(posedge clk);
		hotBitSet <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			wr(OFS_INT_BRIDGE, 4'h4, {14'h0, i[0], i[0], 16'h0});
			@(posedge clk);
			poisonSeen <= 1'b1;
			errMsgSeen <= 1'b1;
			@(posedge clk);
			poisonSeen <= 1'b0;
			errMsgSeen <= 1'b0;
			@(negedge clk);
			chk({poisonReport, errMsgForward}, {i[0], i[0]}, "events");
		end
		wr(OFS_INT_BRIDGE, 4'h4, 32'h001C_0000);
		dec(0, 32'h000A_0000, 0, 2'b10);
		dec(0, 32'h000B_FFFF, 0, 2'b10);
		dec(0, 32'h000C_0000, 1, 2'b00);
		dec(1, 32'h0000_03C0, 0, 2'b10);
		dec(1, 32'h0000_07C0, 1, 2'b01);
		dec(1, 32'h0000_10C0, 1, 2'b10);
		dec(1, 32'h0001_03C0, 0, 2'b00);
		wr(OFS_INT_BRIDGE, 4'h4, 32'h0008_0000);
		dec(1, 32'h0000_07BB, 0, 2'b10);
		dec(1, 32'h0000_03BC, 0, 2'b00);
		dec(1, 32'h0000_0700, 1, 2'b10);
		wr(OFS_INT_BRIDGE, 4'h4, 32'h0);
		dec(0, 32'h000A_0000, 0, 2'b00);
		p = $urandom();
		@(posedge clk);
		preloadStrobe <= 1'b1;
		preloadData <= p[18:0];
		@(posedge clk);
		preloadStrobe <= 1'b0;
		rd(OFS_PM_CAP, {p[18:8], 5'b00011, PM_NEXT_DOWN, PM_CAP_ID});
		rd(OFS_INT_BRIDGE, {16'h0, p[7:0], r[7:0]});
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_PM_CAP, 32'hFFC3_4C01);
		rd(OFS_INT_BRIDGE, 32'h0);
		repeat (3) @(posedge clk);
		end_of_test();
	end
endmodule : tb_bridge_control_pm_capability
